// ---- src/ieu_core.v ----
// Interrupt and exception unit: priority, stacking, vectors, masks and wait state
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "ieu_map.vh"
module ieu_core #(
  parameter [255:0] PAGE0_IMPL = {256{1'b1}},
  parameter [255:0] PAGE1_IMPL = {256{1'b1}},
  parameter [255:0] PAGE2_IMPL = {256{1'b1}},
  parameter [255:0] PAGE3_IMPL = {256{1'b1}}
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Interrupt pins and peripheral requests
  input wire ext_int_pin_n,
  input wire nm_int_pin_n,
  input wire [12:0] periph_flag,
  input wire [12:0] periph_int_en,
  input wire [4:0] sci_flag,
  input wire tx_done_int_en,
  input wire tx_empty_int_en,
  input wire idle_line_int_en,
  input wire rx_int_en,
  // System fault sources and configuration
  input wire watchdog_fail,
  input wire watchdog_disable,
  input wire clk_monitor_fail,
  input wire clk_monitor_en,
  // Core instruction events
  input wire instr_done,
  input wire soft_trap_instr,
  input wire sleep_instr,
  input wire rti_start,
  input wire op_valid,
  input wire [1:0] op_page,
  input wire [7:0] op_code,
  input wire [15:0] op_addr,
  input wire flags_wr,
  input wire [7:0] flags_wdata,
  // Core register values
  input wire [15:0] pc_in,
  input wire [15:0] sp_in,
  input wire [15:0] index_x_in,
  input wire [15:0] index_y_in,
  input wire [7:0] accum_a_in,
  input wire [7:0] accum_b_in,
  input wire [7:0] condition_flags_in,
  // Memory bus master
  output reg mem_req,
  output reg mem_we,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  input wire mem_ack,
  input wire [7:0] mem_rdata,
  // Results to the core
  output reg core_hold,
  output reg pc_load,
  output reg rti_done,
  output reg [15:0] pc_out,
  output reg [15:0] sp_out,
  output reg [15:0] index_x_out,
  output reg [15:0] index_y_out,
  output reg [7:0] accum_a_out,
  output reg [7:0] accum_b_out,
  output reg [7:0] condition_flags_out,
  output reg mask_i,
  output reg mask_x,
  output reg in_wait,
  output reg timer_stop
);
  localparam ST_IDLE = 3'h0;
  localparam ST_STACK = 3'h1;
  localparam ST_VHI = 3'h2;
  localparam ST_VLO = 3'h3;
  localparam ST_WAIT = 3'h4;
  localparam ST_PULL = 3'h5;

  localparam K_NM = 3'h0;
  localparam K_ILL = 3'h1;
  localparam K_SWI = 3'h2;
  localparam K_MK = 3'h3;
  localparam K_SLP = 3'h4;

  // Reset release through two flip-flops
  reg rst_meta_reg;
  reg rst_sync_reg;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  reg [2:0] state_reg;
  reg [2:0] kind_reg;
  reg [3:0] cnt_reg;
  reg [3:0] mk_idx_reg;
  reg [15:0] vec_reg;
  reg [15:0] stk_pc_reg;
  reg [15:0] stk_sp_reg;
  reg [7:0] vhi_reg;
  reg [3:0] psel_reg;
  reg ill_reg;
  reg [15:0] ill_addr_reg;
  reg swi_reg;
  reg slp_reg;

  wire sci_req = (sci_flag[0] & tx_done_int_en) | (sci_flag[1] & tx_empty_int_en) |
    (sci_flag[2] & idle_line_int_en) | ((sci_flag[3] | sci_flag[4]) & rx_int_en);
  wire [14:0] mk_vec = {sci_req, periph_flag & periph_int_en, ~ext_int_pin_n};
  wire mk_any;
  wire [3:0] mk_idx;

  ieu_prio #(
    .N(15)
  ) u_prio (
    .req(mk_vec),
    .psel(psel_reg),
    .any(mk_any),
    .idx(mk_idx)
  );

  wire illegal_now;

  ieu_opchk #(
    .PAGE0_IMPL(PAGE0_IMPL),
    .PAGE1_IMPL(PAGE1_IMPL),
    .PAGE2_IMPL(PAGE2_IMPL),
    .PAGE3_IMPL(PAGE3_IMPL)
  ) u_opchk (
    .op_valid(op_valid),
    .op_page(op_page),
    .op_code(op_code),
    .illegal(illegal_now)
  );

  wire mk_req = mk_any & ~mask_i;
  wire nm_req = ~nm_int_pin_n & ~mask_x;
  wire ill_now = ill_reg | illegal_now;
  wire swi_now = swi_reg | soft_trap_instr;
  wire slp_now = slp_reg | sleep_instr;
  wire cm_hit = clk_monitor_fail & clk_monitor_en;
  wire wd_hit = watchdog_fail & ~watchdog_disable;
  wire mem_done = mem_req & mem_ack;
  wire apb_acc = psel & penable & ~pready;

  wire [2:0] take_kind = nm_req ? K_NM : ill_now ? K_ILL : swi_now ? K_SWI : mk_req ? K_MK : K_SLP;
  wire take_any = nm_req | ill_now | swi_now | mk_req | slp_now;

  function [7:0] stack_byte;
    input [3:0] n;
    input [15:0] pc;
    input [7:0] condition_flags;
    begin
      case (n)
        4'h0: stack_byte = pc[7:0];
        4'h1: stack_byte = pc[15:8];
        4'h2: stack_byte = index_y_in[7:0];
        4'h3: stack_byte = index_y_in[15:8];
        4'h4: stack_byte = index_x_in[7:0];
        4'h5: stack_byte = index_x_in[15:8];
        4'h6: stack_byte = accum_a_in;
        4'h7: stack_byte = accum_b_in;
        default: stack_byte = condition_flags;
      endcase
    end
  endfunction

  wire [7:0] ccr_stk = {condition_flags_in[7], mask_x, condition_flags_in[5], mask_i, condition_flags_in[3:0]};

  wire [15:0] mk_vector = `IEU_VEC_MK_TOP - {11'h0, mk_idx_reg, 1'b0};
  wire [15:0] wake_vector = `IEU_VEC_MK_TOP - {11'h0, mk_idx, 1'b0};

  always @(posedge core_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= ST_VHI;
      vec_reg <= `IEU_VEC_RESET;
      kind_reg <= K_NM;
      cnt_reg <= 4'h0;
      mk_idx_reg <= 4'h0;
      stk_pc_reg <= 16'h0000;
      stk_sp_reg <= 16'h0000;
      vhi_reg <= 8'h00;
      psel_reg <= `IEU_PSEL_RST;
      ill_reg <= 1'b0;
      ill_addr_reg <= 16'h0000;
      swi_reg <= 1'b0;
      slp_reg <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      core_hold <= 1'b1;
      pc_load <= 1'b0;
      rti_done <= 1'b0;
      pc_out <= 16'h0000;
      sp_out <= 16'h0000;
      index_x_out <= 16'h0000;
      index_y_out <= 16'h0000;
      accum_a_out <= 8'h00;
      accum_b_out <= 8'h00;
      condition_flags_out <= 8'h00;
      mask_i <= 1'b1;
      mask_x <= 1'b1;
      in_wait <= 1'b0;
      timer_stop <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      rti_done <= 1'b0;
      timer_stop <= in_wait & mask_i & watchdog_disable;

      // APB slave, one wait state per access
      pready <= apb_acc;
      pslverr <= 1'b0;
      if (apb_acc) begin
        prdata <= 32'h00000000;
        if (paddr == `IEU_PRIO_OFF) begin
          if (pwrite && mask_i) begin
            psel_reg <= pwdata[`IEU_PSEL_LSB +: 4];
          end
          prdata <= {28'h0, psel_reg};
        end else if (paddr == `IEU_STAT_OFF) begin
          prdata <= {23'h0, mk_any, nm_req, in_wait, mask_x, mask_i, core_hold, state_reg};
        end else begin
          pslverr <= 1'b1;
        end
      end

      if (flags_wr) begin
        mask_i <= flags_wdata[`IEU_CCR_I];
        mask_x <= mask_x & flags_wdata[`IEU_CCR_X];
      end

      // Pending instruction events; the clear when taken wins over a new event in the same cycle
      if (illegal_now && !ill_reg) begin
        ill_addr_reg <= op_addr;
      end
      ill_reg <= ill_now;
      swi_reg <= swi_now;
      slp_reg <= slp_now;

      if (mem_done) begin
        mem_req <= 1'b0;
        mem_we <= 1'b0;
      end

      if (cm_hit || wd_hit) begin
        // Fault resets abandon any sequence and restart from their vector
        state_reg <= ST_VHI;
        vec_reg <= cm_hit ? `IEU_VEC_CLKMON : `IEU_VEC_WDOG;
        cnt_reg <= 4'h0;
        mem_req <= 1'b0;
        mem_we <= 1'b0;
        core_hold <= 1'b1;
        in_wait <= 1'b0;
        mask_i <= 1'b1;
        mask_x <= 1'b1;
        ill_reg <= 1'b0;
        swi_reg <= 1'b0;
        slp_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (instr_done && take_any) begin
              state_reg <= ST_STACK;
              kind_reg <= take_kind;
              mk_idx_reg <= mk_idx;
              cnt_reg <= 4'h0;
              core_hold <= 1'b1;
              stk_sp_reg <= sp_in;
              stk_pc_reg <= (take_kind == K_ILL) ? (ill_reg ? ill_addr_reg : op_addr) : pc_in;
              if (take_kind == K_ILL) begin
                ill_reg <= 1'b0;
              end
              if (take_kind == K_SWI) begin
                swi_reg <= 1'b0;
              end
              if (take_kind == K_SLP) begin
                slp_reg <= 1'b0;
              end
            end else if (rti_start) begin
              state_reg <= ST_PULL;
              cnt_reg <= 4'h0;
              core_hold <= 1'b1;
              stk_sp_reg <= sp_in;
            end
          end
          ST_STACK: begin
            if (!mem_req) begin
              mem_req <= 1'b1;
              mem_we <= 1'b1;
              mem_addr <= stk_sp_reg - {12'h0, cnt_reg};
              mem_wdata <= stack_byte(cnt_reg, stk_pc_reg, ccr_stk);
            end else if (mem_done) begin
              cnt_reg <= cnt_reg + 4'h1;
              if (cnt_reg == `IEU_FRAME_LAST) begin
                cnt_reg <= 4'h0;
                state_reg <= ST_VHI;
                mask_i <= 1'b1;
                case (kind_reg)
                  K_NM: begin
                    mask_x <= 1'b1;
                    vec_reg <= `IEU_VEC_NMPIN;
                  end
                  K_ILL: vec_reg <= `IEU_VEC_ILLOP;
                  K_SWI: vec_reg <= `IEU_VEC_SWI;
                  K_MK: vec_reg <= mk_vector;
                  default: begin
                    state_reg <= ST_WAIT;
                    mask_i <= mask_i;
                    in_wait <= 1'b1;
                  end
                endcase
              end
            end
          end
          ST_WAIT: begin
            if (!mem_req) begin
              if (nm_req || mk_req) begin
                in_wait <= 1'b0;
                state_reg <= ST_VHI;
                mask_i <= 1'b1;
                if (nm_req) begin
                  mask_x <= 1'b1;
                  vec_reg <= `IEU_VEC_NMPIN;
                end else begin
                  vec_reg <= wake_vector;
                end
              end else begin
                mem_req <= 1'b1;
                mem_addr <= stk_sp_reg - {12'h0, `IEU_FRAME_LAST};
              end
            end
          end
          ST_VHI: begin
            if (!mem_req) begin
              mem_req <= 1'b1;
              mem_addr <= vec_reg;
            end else if (mem_done) begin
              vhi_reg <= mem_rdata;
              state_reg <= ST_VLO;
            end
          end
          ST_VLO: begin
            if (!mem_req) begin
              mem_req <= 1'b1;
              mem_addr <= vec_reg + 16'h0001;
            end else if (mem_done) begin
              pc_out <= {vhi_reg, mem_rdata};
              sp_out <= stk_sp_reg - `IEU_FRAME_BYTES;
              pc_load <= 1'b1;
              core_hold <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
          ST_PULL: begin
            if (!mem_req) begin
              mem_req <= 1'b1;
              mem_addr <= stk_sp_reg + {12'h0, cnt_reg} + 16'h0001;
            end else if (mem_done) begin
              cnt_reg <= cnt_reg + 4'h1;
              case (cnt_reg)
                4'h0: begin
                  condition_flags_out <= mem_rdata;
                  mask_i <= mem_rdata[`IEU_CCR_I];
                  mask_x <= mem_rdata[`IEU_CCR_X];
                end
                4'h1: accum_b_out <= mem_rdata;
                4'h2: accum_a_out <= mem_rdata;
                4'h3: index_x_out[15:8] <= mem_rdata;
                4'h4: index_x_out[7:0] <= mem_rdata;
                4'h5: index_y_out[15:8] <= mem_rdata;
                4'h6: index_y_out[7:0] <= mem_rdata;
                4'h7: pc_out[15:8] <= mem_rdata;
                default: begin
                  pc_out[7:0] <= mem_rdata;
                  sp_out <= stk_sp_reg + `IEU_FRAME_BYTES;
                  rti_done <= 1'b1;
                  core_hold <= 1'b0;
                  cnt_reg <= 4'h0;
                  state_reg <= ST_IDLE;
                end
              endcase
            end
          end
          default: begin
            state_reg <= ST_IDLE;
            core_hold <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // ieu_core

// ---- inc/ieu_map.vh ----
// Address map, field positions, vectors and reset values of the exception unit
`ifndef IEU_MAP_VH
`define IEU_MAP_VH
// Register byte offsets
`define IEU_PRIO_OFF 8'h00
`define IEU_STAT_OFF 8'h04
// Priority select field
`define IEU_PSEL_LSB 0
`define IEU_PSEL_RST 4'h5
// Status word field positions
`define IEU_ST_STATE_LSB 0
`define IEU_ST_HOLD 3
`define IEU_ST_IMASK 4
`define IEU_ST_XMASK 5
`define IEU_ST_WAIT 6
`define IEU_ST_NMREQ 7
`define IEU_ST_MKREQ 8
// Flags byte bit positions
`define IEU_CCR_X 6
`define IEU_CCR_I 4
// Vector table
`define IEU_VEC_RESET 16'hfffe
`define IEU_VEC_CLKMON 16'hfffc
`define IEU_VEC_WDOG 16'hfffa
`define IEU_VEC_ILLOP 16'hfff8
`define IEU_VEC_SWI 16'hfff6
`define IEU_VEC_NMPIN 16'hfff4
`define IEU_VEC_MK_TOP 16'hfff2
// Stack frame
`define IEU_FRAME_LAST 4'd8
`define IEU_FRAME_BYTES 16'h0009
`endif

// ---- src/ieu_prio.v ----
// Fixed-order maskable priority resolver with one promoted source
`timescale 1ns/10ps
module ieu_prio #(
  parameter N = 15
) (
  // Requests, index 0 highest
  input wire [N-1:0] req,
  input wire [3:0] psel,
  // Winner
  output reg any,
  output reg [3:0] idx
);
  // Select code to source index; code 5 is reserved and falls back to the pin
  function [3:0] promoted;
    input [3:0] p;
    begin
      if (p >= 4'h6) begin
        promoted = p - 4'h6;
      end else if (p == 4'h5) begin
        promoted = 4'h0;
      end else begin
        promoted = p + 4'ha;
      end
    end
  endfunction

  integer k;
  always @* begin
    any = |req;
    idx = 4'h0;
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (req[k]) begin
        idx = k[3:0];
      end
    end
    if (req[promoted(psel)]) begin
      idx = promoted(psel);
    end
  end
endmodule // ieu_prio

// ---- src/ieu_opchk.v ----
// Unimplemented opcode detector over four opcode pages
`timescale 1ns/10ps
module ieu_opchk #(
  parameter [255:0] PAGE0_IMPL = {256{1'b1}},
  parameter [255:0] PAGE1_IMPL = {256{1'b1}},
  parameter [255:0] PAGE2_IMPL = {256{1'b1}},
  parameter [255:0] PAGE3_IMPL = {256{1'b1}}
) (
  // Decoded opcode
  input wire op_valid,
  input wire [1:0] op_page,
  input wire [7:0] op_code,
  // Verdict
  output reg illegal
);
  function implemented;
    input [1:0] pg;
    input [7:0] oc;
    begin
      case (pg)
        2'h0: implemented = PAGE0_IMPL[oc];
        2'h1: implemented = PAGE1_IMPL[oc];
        2'h2: implemented = PAGE2_IMPL[oc];
        default: implemented = PAGE3_IMPL[oc];
      endcase
    end
  endfunction

  always @* begin
    illegal = op_valid & ~implemented(op_page, op_code);
  end
endmodule // ieu_opchk

// ---- testbench/ieu_core_props.sv ----
// Port-level assertions for the exception unit, bound to its top module
`timescale 1ns/10ps
module ieu_core_props (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Register bus
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pready,
  input wire pslverr,
  // Sources and core events
  input wire watchdog_fail,
  input wire watchdog_disable,
  input wire clk_monitor_fail,
  input wire instr_done,
  input wire rti_start,
  input wire flags_wr,
  input wire [7:0] flags_wdata,
  // Memory bus
  input wire mem_req,
  input wire mem_we,
  input wire [15:0] mem_addr,
  input wire mem_ack,
  // State outputs
  input wire core_hold,
  input wire mask_i,
  input wire mask_x,
  input wire in_wait,
  input wire timer_stop
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence wr_done_s;
    mem_req && mem_we && mem_ack;
  endsequence
  sequence vec_rd_s;
    mem_req && !mem_we && mem_addr >= 16'hffc0;
  endsequence
  reset_masks_a: assert property ($rose(rst_n) |-> mask_i && mask_x)
    else $error("masks not set out of reset");
  xmask_sticky_a: assert property (
    flags_wr && flags_wdata[6] && !mask_x && !core_hold && !watchdog_fail && !clk_monitor_fail |=> !mask_x)
    else $error("software set the nm mask");
  stack_down_a: assert property (
    wr_done_s ##2 (mem_req && mem_we) |-> mem_addr == $past(mem_addr, 2) - 16'h0001)
    else $error("stack write out of order");
  // Even address first, so a swapped byte pair shows up here
  vec_pair_a: assert property (
    vec_rd_s and mem_ack && !mem_addr[0] |-> ##2 mem_req && !mem_we && mem_addr == $past(mem_addr, 2) + 16'h0001)
    else $error("vector low byte not at odd address");
  mask_set_a: assert property (wr_done_s ##2 vec_rd_s |-> mask_i)
    else $error("global mask clear at vector fetch");
  wait_read_a: assert property (in_wait && mem_req |-> !mem_we)
    else $error("write cycle in wait state");
  timer_stop_a: assert property (in_wait && mask_i && watchdog_disable |=> timer_stop)
    else $error("timer kept running in wait");
  timer_run_a: assert property (!(in_wait && mask_i && watchdog_disable) |=> !timer_stop)
    else $error("timer stopped without cause");
  entry_start_a: assert property (
    $rose(core_hold) |-> $past(instr_done || rti_start || in_wait || watchdog_fail || clk_monitor_fail))
    else $error("service began off an instruction boundary");
  apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer not one cycle wide");
  bad_offset_a: assert property (psel && penable && pready && paddr != 8'h00 && paddr != 8'h04 |-> pslverr)
    else $error("unmapped offset not refused");
endmodule // ieu_core_props

bind ieu_core ieu_core_props u_ieu_core_props (.core_clk, .rst_n, .psel, .penable, .paddr, .pready, .pslverr,
  .watchdog_fail, .watchdog_disable, .clk_monitor_fail, .instr_done, .rti_start, .flags_wr, .flags_wdata,
  .mem_req, .mem_we, .mem_addr, .mem_ack, .core_hold, .mask_i, .mask_x, .in_wait, .timer_stop);

// ---- testbench/ieu_mem_model.sv ----
// Byte memory answering the exception unit's bus with a chosen delay
`timescale 1ns/10ps
module ieu_mem_model (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Request from the unit
  input wire mem_req,
  input wire mem_we,
  input wire [15:0] mem_addr,
  input wire [7:0] mem_wdata,
  // Answer delay in cycles
  input wire [1:0] lat,
  // Answer
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [1:0] cnt;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
      cnt <= 2'd0;
    end else if (mem_ack) begin
      // Read data goes stale after the ack edge, so a late sample cannot pass
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt <= 2'd0;
      if (mem_we)
        mem[mem_addr] <= mem_wdata;
    end else if (mem_req) begin
      if (cnt == lat) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem[mem_addr];
      end else
        cnt <= cnt + 2'd1;
    end
  end
endmodule // ieu_mem_model

// ---- testbench/ieu_core_tb_top.sv ----
// Self-checking bench for the exception unit
`timescale 1ns/10ps
module ieu_core_tb_top;
  localparam logic [15:0] SP = 16'h01f0;
  localparam logic [15:0] PC = 16'h4321;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, op_code, flags_wdata, accum_a_out, accum_b_out, condition_flags_out, mem_wdata, mem_rdata;
  logic [31:0] pwdata, prdata, rd;
  logic ext_int_pin_n, nm_int_pin_n, tx_done_int_en, tx_empty_int_en, idle_line_int_en, rx_int_en;
  logic [12:0] periph_flag, periph_int_en;
  logic [4:0] sci_flag;
  logic watchdog_fail, watchdog_disable, clk_monitor_fail, clk_monitor_en;
  logic instr_done, soft_trap_instr, sleep_instr, rti_start, op_valid, flags_wr;
  logic [1:0] op_page, lat;
  logic [15:0] op_addr, sp_in, pc_in, pc_out, sp_out, index_x_out, index_y_out, mem_addr;
  logic mem_req, mem_we, mem_ack, core_hold, pc_load, rti_done, mask_i, mask_x, in_wait, timer_stop;
  int bad_count, num_checks;

  ieu_core #(.PAGE2_IMPL(~(256'h1 << 8'h41))) u_ieu_core (.core_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_int_pin_n, .nm_int_pin_n, .periph_flag, .periph_int_en,
    .sci_flag, .tx_done_int_en, .tx_empty_int_en, .idle_line_int_en, .rx_int_en, .watchdog_fail,
    .watchdog_disable, .clk_monitor_fail, .clk_monitor_en, .instr_done, .soft_trap_instr, .sleep_instr,
    .rti_start, .op_valid, .op_page, .op_code, .op_addr, .flags_wr, .flags_wdata, .pc_in, .sp_in,
    .index_x_in(16'hc3d4), .index_y_in(16'ha1b2), .accum_a_in(8'he5), .accum_b_in(8'hf6),
    .condition_flags_in(8'h00), .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .core_hold,
    .pc_load, .rti_done, .pc_out, .sp_out, .index_x_out, .index_y_out, .accum_a_out, .accum_b_out,
    .condition_flags_out, .mask_i, .mask_x, .in_wait, .timer_stop);
  ieu_mem_model u_ieu_mem_model (.core_clk, .rst_n, .mem_req, .mem_we, .mem_addr, .mem_wdata, .lat,
    .mem_ack, .mem_rdata);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setf(input logic [7:0] v);
    @(posedge core_clk);
    flags_wr <= 1'b1;
    flags_wdata <= v;
    @(posedge core_clk);
    flags_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  // Vector bytes are preloaded as their own address, so the target is known
  task automatic serve(input logic [15:0] v, input logic go);
    if (go) begin
      @(posedge core_clk);
      instr_done <= 1'b1;
      @(posedge core_clk);
      instr_done <= 1'b0;
    end
    @(posedge core_clk);
    while (pc_load !== 1'b1) @(posedge core_clk);
    chk(pc_out, {v[7:0], v[7:0] + 8'h01}, "vector target");
  endtask

  task automatic frame(input logic [15:0] pc, input logic mi, input logic mx);
    logic [71:0] e;
    e = {pc[7:0], pc[15:8], 48'hb2a1d4c3e5f6, 1'b0, mx, 1'b0, mi, 4'h0};
    for (int i = 0; i < 9; i++)
      chk(u_ieu_mem_model.mem[SP - i], e[71 - 8 * i -: 8], "stacked byte");
  endtask

  task automatic rti(input logic [15:0] pc, input logic mi, input logic mx);
    @(posedge core_clk);
    sp_in <= SP - 16'h0009;
    rti_start <= 1'b1;
    @(posedge core_clk);
    rti_start <= 1'b0;
    while (rti_done !== 1'b1) @(posedge core_clk);
    chk(pc_out, pc, "return address");
    chk(sp_out, SP, "return stack pointer");
    chk({mask_i, mask_x}, {mi, mx}, "return masks");
    chk({index_y_out, index_x_out}, 32'ha1b2c3d4, "return index registers");
    chk({accum_a_out, accum_b_out, condition_flags_out}, {16'he5f6, 1'b0, mx, 1'b0, mi, 4'h0}, "return acc and flags");
    sp_in <= SP;
  endtask

  task automatic t_reset;
    serve(16'hfffe, 1'b0);
    chk({mask_i, mask_x}, 2'b11, "masks out of reset");
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[3:0], 4'h5, "priority select reset");
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1, "unmapped offset refused");
    chk(rd, 32'h0, "unmapped offset data");
  endtask

  task automatic t_masks;
    setf(8'h00);
    chk({mask_i, mask_x}, 2'b00, "masks cleared");
    setf(8'h40);
    chk(mask_x, 1'b0, "nm mask stays clear");
  endtask

  task automatic t_prio;
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[3:0], 4'h5, "select write while unmasked");
    setf(8'h10);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[3:0], 4'h0, "select write while masked");
    setf(8'h00);
    // Pin held low until serviced, as a wired-OR source must
    ext_int_pin_n <= 1'b0;
    periph_flag <= 13'h0200;
    periph_int_en <= 13'h0200;
    serve(16'hffde, 1'b1);
    chk({mask_i, mask_x}, 2'b10, "maskable entry masks");
    frame(PC, 1'b0, 1'b0);
    rti(PC, 1'b0, 1'b0);
    periph_flag <= 13'h0000;
    serve(16'hfff2, 1'b1);
    ext_int_pin_n <= 1'b1;
    rti(PC, 1'b0, 1'b0);
  endtask

  task automatic t_nm;
    periph_flag <= 13'h0001;
    periph_int_en <= 13'h0001;
    nm_int_pin_n <= 1'b0;
    serve(16'hfff4, 1'b1);
    chk({mask_i, mask_x}, 2'b11, "nm entry masks");
    nm_int_pin_n <= 1'b1;
    periph_flag <= 13'h0000;
    rti(PC, 1'b0, 1'b0);
  endtask

  task automatic t_sci;
    sci_flag <= 5'h08;
    {rx_int_en, idle_line_int_en, tx_empty_int_en, tx_done_int_en} <= 4'h7;
    @(posedge core_clk);
    instr_done <= 1'b1;
    @(posedge core_clk);
    instr_done <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(core_hold, 1'b0, "gated serial source");
    for (int i = 0; i < 5; i++) begin
      sci_flag <= 5'h01 << i;
      {rx_int_en, idle_line_int_en, tx_empty_int_en, tx_done_int_en} <= 4'h1 << (i > 3 ? 3 : i);
      serve(16'hffd6, 1'b1);
      rti(PC, 1'b0, 1'b0);
    end
    sci_flag <= 5'h00;
  endtask

  task automatic t_traps;
    @(posedge core_clk);
    {op_valid, soft_trap_instr, instr_done} <= 3'b111;
    op_page <= 2'd2;
    op_code <= 8'h41;
    op_addr <= 16'h2222;
    lat <= 2'd2;
    @(posedge core_clk);
    {op_valid, soft_trap_instr, instr_done} <= 3'b000;
    serve(16'hfff8, 1'b0);
    frame(16'h2222, 1'b0, 1'b0);
    serve(16'hfff6, 1'b1);
    frame(PC, 1'b1, 1'b0);
    rti(PC, 1'b1, 1'b0);
    lat <= 2'd0;
  endtask

  task automatic t_wait;
    setf(8'h10);
    watchdog_disable <= 1'b1;
    @(posedge core_clk);
    {sleep_instr, instr_done} <= 2'b11;
    @(posedge core_clk);
    {sleep_instr, instr_done} <= 2'b00;
    while (in_wait !== 1'b1) @(posedge core_clk);
    ext_int_pin_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk({in_wait, timer_stop}, 2'b11, "masked pin keeps sleep");
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[8:4], 5'b10101, "status in wait");
    while (mem_req !== 1'b1) @(posedge core_clk);
    chk(mem_addr, SP - 16'h0008, "wait read address");
    frame(PC, 1'b1, 1'b0);
    nm_int_pin_n <= 1'b0;
    serve(16'hfff4, 1'b0);
    {nm_int_pin_n, ext_int_pin_n, watchdog_disable} <= 3'b110;
  endtask

  task automatic t_fault;
    clk_monitor_en <= 1'b1;
    // One-cycle fault pulse; a held fault keeps restarting the vector fetch
    @(posedge core_clk);
    {watchdog_fail, clk_monitor_fail} <= 2'b11;
    @(posedge core_clk);
    {watchdog_fail, clk_monitor_fail} <= 2'b00;
    serve(16'hfffc, 1'b0);
    chk({mask_i, mask_x}, 2'b11, "fault masks");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, periph_flag, periph_int_en, sci_flag, lat} = '0;
    {tx_done_int_en, tx_empty_int_en, idle_line_int_en, rx_int_en, watchdog_fail, watchdog_disable} = '0;
    {clk_monitor_fail, clk_monitor_en, instr_done, soft_trap_instr, sleep_instr, rti_start} = '0;
    {op_valid, op_page, op_code, op_addr, flags_wr, flags_wdata} = '0;
    {ext_int_pin_n, nm_int_pin_n, sp_in, pc_in} = {2'b11, SP, PC};
    bad_count = 0;
    num_checks = 0;
    for (int a = 'hffc0; a < 'h10000; a++)
      u_ieu_mem_model.mem[a] = a[7:0];
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset;
    t_masks;
    t_prio;
    t_nm;
    t_sci;
    t_traps;
    t_wait;
    t_fault;
    tally_and_finish;
  end

  initial begin
    #400000;
    bad_count++;
    tally_and_finish;
  end
endmodule // ieu_core_tb_top
